// file: logic/scetmr_top.sv
/*
 * Slow clock elapsed timer: prescaler, 32-bit count, alarm and flags,
 * with a plain register port.
 * Assumes bus strobes synchronous to ref_clk, one cycle long, and a
 * calendar tick input already one ref_clk cycle wide.
 */
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module scetmr_top
   import scetmr_pkg::*;
#(
   parameter int SLOW_DIV = SCETMR_SLOW_DIV
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [31:0] reg_rdata,
   // calendar second tick
   input  wire logic        calib_tick,
   // interrupt and observation
   output      logic        timer_irq,
   output      logic        slow_tick
);

   // ************************************************************
   // registers
   // ************************************************************
   scetmr_ctrl_type  ctrl_reg;
   logic [31:0]      alarm_value_reg;
   logic [31:0]      count_reg;
   logic [15:0]      presc_reg;
   scetmr_flags_type flags_reg;
   logic [1:0]       clr_pend_reg;
   logic             restart_reg;
   logic [31:0]      rdata_reg;
   logic [31:0]      slow_div_reg;
   logic             calib_pend_reg;

   // ************************************************************
   // decode
   // ************************************************************
   wire wr_ctrl   = reg_wr && (reg_addr == SCETMR_OFS_CTRL);
   wire wr_alarm  = reg_wr && (reg_addr == SCETMR_OFS_ALARM);
   wire rd_status = reg_rd && (reg_addr == SCETMR_OFS_STATUS);

   // slow clock rate as an enable pulse
   wire slow_en = (slow_div_reg == 32'(SLOW_DIV - 1));
   wire run     = !ctrl_reg.timer_off_bit;
   wire step    = slow_en && run;

   // divisor of zero rolls over every 65536 slow periods
   wire [15:0] presc_last = ctrl_reg.prescale_divisor - 16'h0001;
   wire        rollover   = step && (presc_reg == presc_last);

   wire count_adv = ctrl_reg.calib_second_select ?
                    (step && calib_pend_reg) : rollover;
   wire [31:0] count_next = count_reg + 32'h0000_0001;

   wire alarm_hit = step && (count_reg == alarm_value_reg);

   scetmr_flags_type flags_next;
   always_comb begin
      flags_next = flags_reg;
      // pending clear lands on its second slow edge
      if (step && clr_pend_reg == 2'(SCETMR_CLR_DELAY)) begin
         flags_next = '0;
      end
      if (rollover) begin
         flags_next.increment_flag = 1'b1;
      end
      if (alarm_hit) begin
         flags_next.alarm_flag = 1'b1;
      end
   end

   wire [31:0] ctrl_word = {7'h00, ctrl_reg.calib_second_select,
                            3'h0, ctrl_reg.timer_off_bit, 1'b0, 1'b0,
                            ctrl_reg.increment_irq_enable,
                            ctrl_reg.alarm_irq_enable,
                            ctrl_reg.prescale_divisor};

   // single clock, so reads see count and flags directly
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         SCETMR_OFS_CTRL:   rd_mux = ctrl_word;
         SCETMR_OFS_ALARM:  rd_mux = alarm_value_reg;
         SCETMR_OFS_VALUE:  rd_mux = count_reg;
         SCETMR_OFS_STATUS: rd_mux = {30'h0000_0000, flags_reg};
         default:           rd_mux = SCETMR_ZERO;
      endcase
   end

   // ************************************************************
   // slow enable divider
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_div_reg <= SCETMR_ZERO;
      end else if (slow_en) begin
         slow_div_reg <= SCETMR_ZERO;
      end else begin
         slow_div_reg <= slow_div_reg + 32'h0000_0001;
      end
   end

   // ************************************************************
   // control and alarm registers
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg        <= '0;
         ctrl_reg.prescale_divisor <= SCETMR_CTRL_RESET[15:0];
         alarm_value_reg <= SCETMR_ALARM_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg.prescale_divisor     <= reg_wdata[15:0];
            ctrl_reg.alarm_irq_enable     <= reg_wdata[SCETMR_POS_ALM_IEN];
            ctrl_reg.increment_irq_enable <= reg_wdata[SCETMR_POS_INC_IEN];
            ctrl_reg.timer_off_bit        <= reg_wdata[SCETMR_POS_OFF];
            ctrl_reg.calib_second_select  <= reg_wdata[SCETMR_POS_CALIB];
         end
         if (wr_alarm) begin
            alarm_value_reg <= reg_wdata;
         end
      end
   end

   // ************************************************************
   // prescaler, counter, flags
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         restart_reg    <= 1'b0;
         presc_reg      <= 16'h0000;
         count_reg      <= SCETMR_ZERO;
         flags_reg      <= '0;
         clr_pend_reg   <= 2'b00;
         calib_pend_reg <= 1'b0;
      end else begin
         restart_reg <= wr_ctrl && reg_wdata[SCETMR_POS_RESTART];
         // hold a calendar tick until the next slow step takes it
         if (calib_tick) begin
            calib_pend_reg <= 1'b1;
         end else if (step) begin
            calib_pend_reg <= 1'b0;
         end
         // restart acts the cycle after the write, new divisor in place
         if (restart_reg) begin
            presc_reg <= 16'h0000;
            count_reg <= SCETMR_ZERO;
         end else begin
            if (rollover) begin
               presc_reg <= 16'h0000;
            end else if (step) begin
               presc_reg <= presc_reg + 16'h0001;
            end
            if (count_adv) begin
               count_reg <= count_next;
            end
         end
         flags_reg <= flags_next;
         if (rd_status) begin
            clr_pend_reg <= 2'b01;
         end else if (step && clr_pend_reg != 2'b00) begin
            clr_pend_reg <= (clr_pend_reg == 2'(SCETMR_CLR_DELAY)) ?
                            2'b00 : clr_pend_reg + 2'b01;
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= SCETMR_ZERO;
         timer_irq <= 1'b0;
         slow_tick <= 1'b0;
      end else begin
         rdata_reg <= reg_rd ? rd_mux : SCETMR_ZERO;
         timer_irq <= (flags_next.increment_flag &&
                       ctrl_reg.increment_irq_enable) ||
                      (flags_next.alarm_flag &&
                       ctrl_reg.alarm_irq_enable);
         slow_tick <= step;
      end
   end

   assign reg_rdata = rdata_reg;

endmodule // scetmr_top

// file: logic/scetmr_pkg.sv
/*
 * Constants and carrier types for the slow clock elapsed timer.
 * Assumes one clock (ref_clk) with the slow clock rate delivered as an
 * enable pulse, and the calendar 1 Hz tick as a one-cycle enable pulse.
 */
//
// Contract
// - 32-bit counter advances on 16-bit prescaler roll-over.
// - counter wraps from all ones to zero.
// - divisor 8000 hex gives one second.
// - calib select uses calendar tick for counter.
// - increment flag set on every prescaler roll-over.
// - alarm flag set when count equals alarm.
// - alarm value resets to all ones.
// - status read clears both flags.
// - flag clear lands two slow cycles later.
// - count value readable at any time.
// - restart reloads prescaler and zeroes counter.
// - timer off bit stops all counting.
// - divisor zero means 65536 slow periods.
// - interrupt is enabled flags ored together.
package scetmr_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [3:0]  SCETMR_OFS_CTRL   = 4'h0;
   localparam logic [3:0]  SCETMR_OFS_ALARM  = 4'h4;
   localparam logic [3:0]  SCETMR_OFS_VALUE  = 4'h8;
   localparam logic [3:0]  SCETMR_OFS_STATUS = 4'hC;

   localparam logic [31:0] SCETMR_CTRL_RESET  = 32'h0000_8000;
   localparam logic [31:0] SCETMR_ALARM_RESET = 32'hFFFF_FFFF;
   localparam logic [31:0] SCETMR_ZERO        = 32'h0000_0000;

   // ************************************************************
   // control and status field positions
   // ************************************************************
   localparam int SCETMR_POS_ALM_IEN = 16;
   localparam int SCETMR_POS_INC_IEN = 17;
   localparam int SCETMR_POS_RESTART = 18;
   localparam int SCETMR_POS_OFF     = 20;
   localparam int SCETMR_POS_CALIB   = 24;
   localparam int SCETMR_POS_ALMFLAG = 0;
   localparam int SCETMR_POS_INCFLAG = 1;

   // ************************************************************
   // timing
   // ************************************************************
   localparam real SCETMR_CLK_MHZ    = 125.0;
   localparam real SCETMR_SLOW_KHZ   = 32.768;
   // slow clock enable period in ref_clk cycles, rounded down
   localparam int  SCETMR_SLOW_DIV   =
      int'($floor(SCETMR_CLK_MHZ * 1000.0 / SCETMR_SLOW_KHZ));
   localparam int  SCETMR_CLR_DELAY  = 2;

   typedef struct packed {
      logic        calib_second_select;
      logic        timer_off_bit;
      logic        increment_irq_enable;
      logic        alarm_irq_enable;
      logic [15:0] prescale_divisor;
   } scetmr_ctrl_type;

   typedef struct packed {
      logic increment_flag;
      logic alarm_flag;
   } scetmr_flags_type;

endpackage

// file: test/scetmr_assertions.sv
/* Port timing checker for scetmr_top.
   Assumes SLOW_DIV equals the value of the bound instance. */
`timescale 1ns/1ps
module scetmr_assertions
   import scetmr_pkg::*;
#(
   parameter int SLOW_DIV = 4
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // events
   input wire logic        calib_tick,
   input wire logic        timer_irq,
   input wire logic        slow_tick
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ************
   // helpers
   // ************
   logic        wr_ctrl;
   logic        rst_slow;
   logic [15:0] gap_reg;
   logic [15:0] gap_next;
   assign wr_ctrl  = reg_wr && reg_addr == SCETMR_OFS_CTRL;
   // divisor 1 may roll before the read lands
   assign rst_slow = wr_ctrl && reg_wdata[SCETMR_POS_RESTART]
      && !reg_wdata[SCETMR_POS_CALIB] && reg_wdata[15:0] != 16'h0001;
   // saturates so a long stop never looks like a short gap
   assign gap_next = slow_tick ? 16'h0000 :
      gap_reg + {15'h0000, gap_reg != 16'hFFFF};
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_reg <= 16'hFFFF;
      end else begin
         gap_reg <= gap_next;
      end
   end
   sequence s_wr_rd(logic w, logic [3:0] a);
      w ##1 !reg_wr ##1 reg_rd && reg_addr == a;
   endsequence
   AST_RDATA_IDLE:
      assert property (!$past(reg_rd) |-> reg_rdata == SCETMR_ZERO)
      else $error("read data not zero outside answer");
   AST_CTRL_RB:
      assert property (s_wr_rd(wr_ctrl, SCETMR_OFS_CTRL) |=>
         reg_rdata == ($past(reg_wdata, 3) & 32'h0113_FFFF))
      else $error("control readback wrong");
   AST_ALARM_RB:
      assert property (s_wr_rd(reg_wr && reg_addr == SCETMR_OFS_ALARM,
         SCETMR_OFS_ALARM) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("alarm readback wrong");
   AST_RESTART_ZERO:
      assert property (s_wr_rd(rst_slow, SCETMR_OFS_VALUE) |=>
         reg_rdata == SCETMR_ZERO)
      else $error("count not zero after restart");
   AST_SLOW_GAP:
      assert property (slow_tick |-> gap_reg >= 16'(SLOW_DIV - 1))
      else $error("slow steps too close");
   AST_IRQ_HOLD:
      assert property (reg_rd && reg_addr == SCETMR_OFS_STATUS
         && timer_irq ##1 !reg_wr |=> timer_irq)
      else $error("interrupt dropped too soon after status read");
   AST_OFF_STOP:
      assert property (wr_ctrl && reg_wdata[SCETMR_POS_OFF]
         ##1 !reg_wr [*4] |=> !slow_tick)
      else $error("slow step while stopped");
   AST_IRQ_GATE:
      assert property (wr_ctrl && reg_wdata[17:16] == 2'b00
         ##1 !reg_wr |=> !timer_irq)
      else $error("interrupt with both enables clear");
endmodule // scetmr_assertions

bind scetmr_top scetmr_assertions #(.SLOW_DIV(SLOW_DIV)) u_scetmr_assertions (
   .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .calib_tick, .timer_irq, .slow_tick);

// file: test/scetmr_top_test.sv
/* Bench for scetmr_top: reset values, readback, counting, clearing,
   calendar tick and interrupt gating. Assumes SLOW_DIV is shortened. */
`timescale 1ns/1ps
module scetmr_top_test;
   import scetmr_pkg::*;
   localparam int SD = 4;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        calib_tick = 1'b0;
   logic [31:0] reg_rdata;
   logic        timer_irq;
   logic        slow_tick;
   logic [31:0] data;
   logic [31:0] v;
   int          failures = 0;
   int          compares = 0;
   int          ticks = 0;
   int          d;
   int          m;
   int          i;
   logic [3:0]  addr_q[$] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
   logic [31:0] exp_q[$] = '{SCETMR_CTRL_RESET, SCETMR_ALARM_RESET,
                             SCETMR_ZERO, SCETMR_ZERO, SCETMR_ZERO};
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (slow_tick === 1'b1) begin
         ticks++;
      end
   end
   scetmr_top #(.SLOW_DIV(SD)) u_scetmr_top (.ref_clk, .rst_b, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .calib_tick, .timer_irq,
      .slow_tick);
   // ************
   // tasks
   // ************
   task automatic final_report;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] w);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic wait_ticks(input int n);
      int t0;
      int k;
      t0 = ticks;
      for (k = 0; k < n * SD * 3 && ticks - t0 < n; k++) begin
         @(posedge ref_clk);
      end
      if (ticks - t0 < n) begin
         failures++;
         final_report();
      end
   endtask
   // ************
   // tests
   // ************
   initial begin
      void'($urandom(32'hdb00));
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (i = 0; i < 5; i++) begin
         rd(addr_q[i], exp_q[i]);
      end
      v = $urandom;
      wr(SCETMR_OFS_ALARM, v);
      rd(SCETMR_OFS_ALARM, v);
      v = ($urandom & 32'h0117_FFFF) | 32'h0010_0000;
      wr(SCETMR_OFS_CTRL, v);
      rd(SCETMR_OFS_CTRL, v & 32'h0113_FFFF);
      wr(SCETMR_OFS_CTRL, 32'h0010_8000);
      $display("reset and readback done");
      // margin of two steps either side of a roll-over
      for (i = 0; i < 4; i++) begin
         d = 5 + $urandom_range(0, 3);
         m = $urandom_range(2, 5);
         wr(SCETMR_OFS_ALARM, 32'($urandom_range(1, m - 1)));
         wr(SCETMR_OFS_CTRL, 32'(d) | 32'h0004_0000);
         wait_ticks(m * d + 2);
         wr(SCETMR_OFS_CTRL, 32'(d) | 32'h0010_0000);
         rd(SCETMR_OFS_VALUE, 32'(m));
         rd(SCETMR_OFS_STATUS, 32'h0000_0003);
      end
      $display("counting done");
      wr(SCETMR_OFS_ALARM, SCETMR_ALARM_RESET);
      wr(SCETMR_OFS_CTRL, 32'h0004_0000);
      rd(SCETMR_OFS_VALUE, SCETMR_ZERO);
      rd(SCETMR_OFS_STATUS, 32'h0000_0003);
      wait_ticks(3);
      rd(SCETMR_OFS_STATUS, SCETMR_ZERO);
      wr(SCETMR_OFS_CTRL, 32'h0104_0000);
      for (i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         calib_tick <= 1'b1;
         @(posedge ref_clk);
         calib_tick <= 1'b0;
         wait_ticks(2);
      end
      rd(SCETMR_OFS_VALUE, 32'h0000_0003);
      rd(SCETMR_OFS_VALUE, 32'h0000_0003);
      $display("clear and calendar done");
      // restart so the prescaler is below the new short divisor
      wr(SCETMR_OFS_CTRL, 32'h0006_0003);
      for (i = 0; i < 40 && timer_irq !== 1'b1; i++) begin
         @(posedge ref_clk);
      end
      chk({31'h0000_0000, timer_irq}, 32'h0000_0001);
      if (i == 40) final_report();
      rd(SCETMR_OFS_STATUS, 32'h0000_0002);
      wr(SCETMR_OFS_CTRL, 32'h0000_0003);
      @(posedge ref_clk);
      #1;
      chk({31'h0000_0000, timer_irq}, SCETMR_ZERO);
      $display("interrupt done");
      final_report();
   end
endmodule // scetmr_top_test
